// ### sbsi_regs.svh
// Constants for the parallel bus signal layer, both ends
`ifndef SBSI_REGS_SVH
`define SBSI_REGS_SVH
`define SBSI_CLK_HZ        10000000
`define SBSI_FREE_DLY_NS   800
`define SBSI_ARB_DLY_NS    2200
`define SBSI_FREE_CYC      ((`SBSI_FREE_DLY_NS * (`SBSI_CLK_HZ / 1000000) + 999) / 1000)
`define SBSI_ARB_CYC       ((`SBSI_ARB_DLY_NS * (`SBSI_CLK_HZ / 1000000) + 999) / 1000)
`define SBSI_CNT_W         6
`define SBSI_DATA_W        8
`define SBSI_BUF_DEPTH     2
`endif

// ### sbsi_pkg.sv
// Types shared by both ends of the bus signal layer
package sbsi_pkg;
  typedef logic [7:0] sbsi_byte_t;   // One data bus byte
  typedef logic [2:0] sbsi_phase_t;  // Phase code as {msg, cd, io}
endpackage

// ### sbsi_bus_if.sv
// Shared bus carrier: wired-OR resolution of both parties' drivers
`timescale 1ns/1ps
interface sbsi_bus_if;
  // Assert levels per party (1 = pulling line to asserted level)
  logic [7:0] tgt_db_oe;   // Target data drivers
  logic       tgt_dbp_oe;  // Target parity driver
  logic       tgt_bsy_oe;  // Target busy
  logic       tgt_sel_oe;  // Target select (reselection)
  logic       tgt_req_oe;  // Target request
  logic       tgt_cd_oe;   // Target control/data
  logic       tgt_io_oe;   // Target input/output
  logic       tgt_msg_oe;  // Target message
  logic       tgt_rst_oe;  // Target reset
  logic [7:0] ini_db_oe;   // Initiator data drivers
  logic       ini_dbp_oe;  // Initiator parity driver
  logic       ini_bsy_oe;  // Initiator busy
  logic       ini_sel_oe;  // Initiator select
  logic       ini_ack_oe;  // Initiator acknowledge
  logic       ini_atn_oe;  // Initiator attention
  logic       ini_rst_oe;  // Initiator reset
  // Resolved asserted levels (wired-OR on db, dbp, bsy, sel and rst; one driver elsewhere)
  logic [7:0] db;
  logic       dbp, bsy, sel, req, ack, atn, rst, cd, io, msg;
  assign db  = tgt_db_oe | ini_db_oe;
  assign dbp = tgt_dbp_oe | ini_dbp_oe;
  assign bsy = tgt_bsy_oe | ini_bsy_oe;
  assign sel = tgt_sel_oe | ini_sel_oe;
  assign req = tgt_req_oe;
  assign ack = ini_ack_oe;
  assign atn = ini_atn_oe;
  assign rst = tgt_rst_oe | ini_rst_oe;
  assign cd  = tgt_cd_oe;
  assign io  = tgt_io_oe;
  assign msg = tgt_msg_oe;
  modport target (output tgt_db_oe, tgt_dbp_oe, tgt_bsy_oe, tgt_sel_oe, tgt_req_oe,
                  tgt_cd_oe, tgt_io_oe, tgt_msg_oe, tgt_rst_oe,
                  input db, dbp, bsy, sel, ack, atn, rst);
  modport initiator (output ini_db_oe, ini_dbp_oe, ini_bsy_oe, ini_sel_oe, ini_ack_oe,
                     ini_atn_oe, ini_rst_oe,
                     input db, dbp, bsy, sel, req, rst, cd, io, msg);
endinterface

// ### sbsi_target.sv
// Target end: arbitration, reselection and request/acknowledge byte transfers
`timescale 1ns/1ps
`include "sbsi_regs.svh"
module sbsi_target (
  input  wire logic               I_CLK,        // 10 MHz clock
  input  wire logic               I_ARST_N,     // Async reset, active low
  sbsi_bus_if.target              bus,          // Bus side
  input  wire logic [2:0]         I_OWN_ID,     // Own bus ID (bit number)
  input  wire logic [2:0]         I_PEER_ID,    // Initiator ID to reselect
  input  wire logic               I_PAR_CHK_EN, // Enable receive parity check
  input  wire logic               I_START,      // Pulse: arbitrate and reselect
  input  wire logic               I_RELEASE,    // Pulse: leave bus when idle
  input  wire sbsi_pkg::sbsi_phase_t I_PHASE,   // Phase to present {msg,cd,io}
  input  wire logic               I_TX_VALID,   // Byte to send offered
  output logic                    O_TX_READY,   // Byte to send accepted
  input  wire logic [7:0]         I_TX_DATA,    // Byte to send
  input  wire logic               I_RX_REQ,     // Ask for one inbound byte
  output logic                    O_RX_VALID,   // Received byte available
  input  wire logic               I_RX_READY,   // Consumer takes byte
  output logic [7:0]              O_RX_DATA,    // Received byte
  output logic                    O_PAR_ERR,    // Pulse: bad parity on receive
  output logic                    O_ATN,        // Attention seen, level
  output logic                    O_BUS_RST,    // Bus reset seen, level
  output logic                    O_CONNECTED,  // Holding the bus
  output logic                    O_ARB_LOST    // Pulse: arbitration lost
);
  typedef enum logic [2:0] {S_IDLE, S_FREEWAIT, S_ARB, S_RESEL, S_CONN, S_XFER, S_DONE}
    sbsi_tstate_e;
  sbsi_tstate_e state;          // Sequencer state
  logic [`SBSI_CNT_W-1:0] cnt;  // Delay counter
  // Two-flop synchronisers for all incoming lines
  logic [12:0] sync1, sync2;
  logic [7:0]  s_db;
  logic        s_dbp, s_bsy, s_sel, s_ack, s_atn, s_rst;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sync1 <= 13'h0000;
      sync2 <= 13'h0000;
    end else begin
      sync1 <= {bus.db, bus.dbp, bus.bsy, bus.sel, bus.ack, bus.atn};
      sync2 <= sync1;
    end
  end
  assign s_db  = sync2[12:5];
  assign s_dbp = sync2[4];
  assign s_bsy = sync2[3];
  assign s_sel = sync2[2];
  assign s_ack = sync2[1];
  assign s_atn = sync2[0];
  // Reset line has its own synchroniser
  logic rst1, rst2;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst1 <= 1'b0;
      rst2 <= 1'b0;
    end else begin
      rst1 <= bus.rst;
      rst2 <= rst1;
    end
  end
  assign s_rst = rst2;
  // Decode: bus free and arbitration win
  wire       bus_free = !s_bsy && !s_sel;
  wire [7:0] own_bit  = 8'h01 << I_OWN_ID;
  wire [7:0] higher   = ~((own_bit << 1) - 8'h01);         // Bits above own
  wire       arb_win  = (s_db & higher) == 8'h00 && !s_sel;
  wire       in_arb   = (state == S_ARB);
  wire       par_odd  = ^{s_db, s_dbp};
  // Two-entry transmit buffer; a stalled sequencer fills it
  sbsi_pkg::sbsi_byte_t txb [`SBSI_BUF_DEPTH];
  logic [1:0] tx_cnt;
  logic       tx_rp, tx_wp;
  wire        tx_push = I_TX_VALID && O_TX_READY;
  wire        tx_pop;
  assign O_TX_READY = (tx_cnt != 2'h2);
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      tx_cnt <= 2'h0;
      tx_rp  <= 1'b0;
      tx_wp  <= 1'b0;
    end else begin
      if (tx_push) txb[tx_wp] <= I_TX_DATA;
      tx_wp  <= tx_wp ^ tx_push;
      tx_rp  <= tx_rp ^ tx_pop;
      tx_cnt <= tx_cnt + {1'b0, tx_push} - {1'b0, tx_pop};
    end
  end
  // Transfer direction from phase: io=1 means data toward initiator
  wire        dir_in   = I_PHASE[0];
  wire        tx_have  = (tx_cnt != 2'h0);
  wire        can_go   = dir_in ? tx_have : (I_RX_REQ && !O_RX_VALID);
  assign tx_pop = (state == S_DONE) && !s_ack && dir_in;
  // Bus drive registers
  logic [7:0] db_drv;
  logic       bsy_drv, sel_drv, req_drv, dbp_en;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state <= S_IDLE; cnt <= '0; db_drv <= 8'h00; dbp_en <= 1'b0;
      bsy_drv <= 1'b0; sel_drv <= 1'b0; req_drv <= 1'b0;
      O_RX_VALID <= 1'b0; O_RX_DATA <= 8'h00; O_PAR_ERR <= 1'b0; O_ARB_LOST <= 1'b0;
    end else begin
      O_PAR_ERR  <= 1'b0;
      O_ARB_LOST <= 1'b0;
      if (O_RX_VALID && I_RX_READY) O_RX_VALID <= 1'b0;
      if (s_rst) begin
        // Abandon everything and let go of every line
        state <= S_IDLE; db_drv <= 8'h00; dbp_en <= 1'b0;
        bsy_drv <= 1'b0; sel_drv <= 1'b0; req_drv <= 1'b0;
      end else begin
        unique case (state)
          S_IDLE: begin
            cnt <= '0;
            if (I_START) state <= S_FREEWAIT;
          end
          S_FREEWAIT: begin
            // Bus must stay free for the whole delay
            if (!bus_free) cnt <= '0;
            else if (cnt == `SBSI_CNT_W'(`SBSI_FREE_CYC - 1)) begin
              bsy_drv <= 1'b1;
              db_drv  <= own_bit;
              cnt     <= '0;
              state   <= S_ARB;
            end else cnt <= cnt + 1'b1;
          end
          S_ARB: begin
            // Look at the data bus only after the arbitration delay
            if (cnt == `SBSI_CNT_W'(`SBSI_ARB_CYC - 1)) begin
              if (arb_win) begin
                sel_drv <= 1'b1;
                db_drv  <= own_bit | (8'h01 << I_PEER_ID);
                cnt     <= '0;                            // Restart for busy echo wait
                state   <= S_RESEL;
              end else begin
                bsy_drv <= 1'b0; db_drv <= 8'h00;
                O_ARB_LOST <= 1'b1;
                state <= S_IDLE;
              end
            end else cnt <= cnt + 1'b1;
          end
          S_RESEL: begin
            // Initiator answers with busy; then we take busy back and drop select.
            // Our own busy echoes through the synchroniser for two cycles, so
            // busy seen before then is ours, not the initiator's answer.
            bsy_drv <= 1'b0;
            if (cnt != `SBSI_CNT_W'(2)) cnt <= cnt + 1'b1;
            else if (s_bsy && !bsy_drv) begin
              bsy_drv <= 1'b1; sel_drv <= 1'b0; db_drv <= 8'h00;
              state <= S_CONN;
            end
          end
          S_CONN: begin
            if (I_RELEASE) begin
              bsy_drv <= 1'b0; state <= S_IDLE;
            end else if (can_go && !s_ack) begin
              db_drv  <= dir_in ? txb[tx_rp] : 8'h00;
              dbp_en  <= dir_in;
              req_drv <= 1'b1;
              state   <= S_XFER;
            end
          end
          S_XFER: begin
            if (s_ack) begin
              if (!dir_in) begin
                O_RX_DATA  <= s_db;
                O_RX_VALID <= 1'b1;
                O_PAR_ERR  <= I_PAR_CHK_EN && !in_arb && !par_odd;
              end
              req_drv <= 1'b0;
              state   <= S_DONE;
            end
          end
          S_DONE: begin
            // Wait for acknowledge to drop before the next byte
            if (!s_ack) begin
              db_drv <= 8'h00; dbp_en <= 1'b0;
              state  <= S_CONN;
            end
          end
        endcase
      end
    end
  end
  // Drivers: only pull or release
  assign bus.tgt_db_oe  = db_drv;
  assign bus.tgt_dbp_oe = dbp_en && !(^db_drv);            // Odd parity
  assign bus.tgt_bsy_oe = bsy_drv;
  assign bus.tgt_sel_oe = sel_drv;
  assign bus.tgt_req_oe = req_drv;
  wire   phase_on       = (state == S_CONN) || (state == S_XFER) || (state == S_DONE);
  assign bus.tgt_cd_oe  = phase_on && I_PHASE[1];
  assign bus.tgt_io_oe  = phase_on && I_PHASE[0];
  assign bus.tgt_msg_oe = phase_on && I_PHASE[2];
  assign bus.tgt_rst_oe = 1'b0;
  assign O_ATN       = s_atn;
  assign O_BUS_RST   = s_rst;
  assign O_CONNECTED = phase_on;
endmodule // sbsi_target

// ### sbsi_initiator.sv
// Initiator end: answers target requests, raises attention and bus reset
`timescale 1ns/1ps
`include "sbsi_regs.svh"
module sbsi_initiator (
  input  wire logic        I_CLK,       // 10 MHz clock
  input  wire logic        I_ARST_N,    // Async reset, active low
  sbsi_bus_if.initiator    bus,         // Bus side
  input  wire logic [2:0]  I_OWN_ID,    // Own bus ID
  input  wire logic        I_ATN,       // Hold attention, level
  input  wire logic        I_BUS_RST,   // Drive bus reset, level
  input  wire logic        I_TX_VALID,  // Outbound byte offered
  output logic             O_TX_READY,  // Outbound byte accepted
  input  wire logic [7:0]  I_TX_DATA,   // Outbound byte
  output logic             O_RX_VALID,  // Inbound byte held
  input  wire logic        I_RX_READY,  // Consumer takes byte
  output logic [7:0]       O_RX_DATA,   // Inbound byte
  output logic [2:0]       O_PHASE,     // Phase seen {msg,cd,io}
  output logic             O_CONNECTED  // Reselected, held until busy and select are both free or a bus reset is seen
);
  // Two-flop synchronisers on all incoming lines except parity
  logic [14:0] sync1, sync2;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sync1 <= 15'h0000;
      sync2 <= 15'h0000;
    end else begin
      sync1 <= {bus.db, bus.bsy, bus.sel, bus.req, bus.rst, bus.msg, bus.cd, bus.io};
      sync2 <= sync1;
    end
  end
  wire [7:0] s_db  = sync2[14:7];
  wire       s_bsy = sync2[6];
  wire       s_sel = sync2[5];
  wire       s_req = sync2[4];
  wire       s_rst = sync2[3];
  wire [2:0] s_ph  = sync2[2:0];
  wire [7:0] own_bit = 8'h01 << I_OWN_ID;
  wire       resel   = s_sel && s_bsy == 1'b0 && (s_db & own_bit) != 8'h00;
  wire       dir_out = !s_ph[0];
  // Two-entry outbound buffer
  sbsi_pkg::sbsi_byte_t txb [`SBSI_BUF_DEPTH];
  logic [1:0] tx_cnt;
  logic       tx_rp, tx_wp;
  logic       conn, ack_drv, dbp_en;
  logic [7:0] db_drv;
  wire        tx_push = I_TX_VALID && O_TX_READY;
  wire        take    = conn && s_req && !ack_drv && !s_rst &&
                        (dir_out ? (tx_cnt != 2'h0) : !O_RX_VALID);
  wire        tx_pop  = take && dir_out;
  assign O_TX_READY = (tx_cnt != 2'h2);
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      tx_cnt <= 2'h0;
      tx_rp  <= 1'b0;
      tx_wp  <= 1'b0;
    end else begin
      if (tx_push) txb[tx_wp] <= I_TX_DATA;
      tx_wp  <= tx_wp ^ tx_push;
      tx_rp  <= tx_rp ^ tx_pop;
      tx_cnt <= tx_cnt + {1'b0, tx_push} - {1'b0, tx_pop};
    end
  end
  // Connection and acknowledge sequencing
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      conn <= 1'b0; ack_drv <= 1'b0; dbp_en <= 1'b0; db_drv <= 8'h00;
      O_RX_VALID <= 1'b0; O_RX_DATA <= 8'h00;
    end else begin
      if (O_RX_VALID && I_RX_READY) O_RX_VALID <= 1'b0;
      if (s_rst) begin
        conn <= 1'b0; ack_drv <= 1'b0; dbp_en <= 1'b0; db_drv <= 8'h00;
      end else begin
        if (resel) conn <= 1'b1;
        else if (conn && !s_bsy && !s_sel) conn <= 1'b0;  // Bus free ends link
        if (take) begin
          ack_drv <= 1'b1;
          if (dir_out) begin
            db_drv <= txb[tx_rp];
            dbp_en <= 1'b1;
          end else begin
            O_RX_DATA  <= s_db;
            O_RX_VALID <= 1'b1;
          end
        end else if (ack_drv && !s_req) begin
          ack_drv <= 1'b0; db_drv <= 8'h00; dbp_en <= 1'b0;
        end
      end
    end
  end
  // Busy answers reselection until busy shows on the synchronised line
  assign bus.ini_bsy_oe = resel && !s_rst;
  assign bus.ini_db_oe  = db_drv;
  assign bus.ini_dbp_oe = dbp_en && !(^db_drv);            // Odd parity
  assign bus.ini_sel_oe = 1'b0;
  assign bus.ini_ack_oe = ack_drv;
  assign bus.ini_atn_oe = I_ATN && !s_rst;
  assign bus.ini_rst_oe = I_BUS_RST;
  assign O_PHASE        = s_ph;
  assign O_CONNECTED    = conn;
endmodule // sbsi_initiator

// ### sbsi_chk_sva.sv
// Checker on the shared bus lines between the two ends
`timescale 1ns/1ps
module sbsi_chk (
  input  wire logic       I_CLK,       // Bench clock
  input  wire logic       I_ARST_N,    // Async reset, active low
  input  wire logic [7:0] db,          // Resolved data
  input  wire logic       dbp,         // Resolved parity
  input  wire logic       bsy,         // Resolved busy
  input  wire logic       sel,         // Resolved select
  input  wire logic       req,         // Request
  input  wire logic       ack,         // Acknowledge
  input  wire logic       rst,         // Bus reset
  input  wire logic       cd,          // Control/data
  input  wire logic       io,          // Input/output
  input  wire logic       msg,         // Message
  input  wire logic [7:0] tgt_db_oe,   // Target data drive
  input  wire logic       tgt_bsy_oe,  // Target busy drive
  input  wire logic       tgt_sel_oe,  // Target select drive
  input  wire logic       tgt_req_oe,  // Target request drive
  input  wire logic       ini_ack_oe   // Initiator acknowledge drive
);
  logic [3:0] rst_hist;  // Recent bus reset samples
  logic [5:0] free_cnt;  // Cycles with busy and select free
  logic [5:0] arb_cnt;   // Cycles target has held busy
  // Transfers cut by a bus reset are exempt for a few cycles
  wire        quiet = !rst && (rst_hist == 4'h0);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  // Span counters saturate so a long idle cannot wrap
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_hist <= 4'h0;
      free_cnt <= 6'h00;
      arb_cnt  <= 6'h00;
    end else begin
      rst_hist <= {rst_hist[2:0], rst};
      free_cnt <= (bsy || sel) ? 6'h00 : free_cnt + {5'h00, free_cnt != 6'h3f};
      arb_cnt  <= !tgt_bsy_oe ? 6'h00 : arb_cnt + {5'h00, arb_cnt != 6'h3f};
    end
  end
  a_tgt_par_odd: assert property (quiet && req && io |-> ^{db, dbp})
    else $error("even parity on target byte");
  a_ini_par_odd: assert property (quiet && ack && !io |-> ^{db, dbp})
    else $error("even parity on initiator byte");
  a_req_held: assert property (quiet && req && !ack |=> req)
    else $error("request dropped before acknowledge");
  a_ack_held: assert property (quiet && ack && req |=> ack)
    else $error("acknowledge dropped while request stands");
  a_ack_answers_req: assert property (disable iff (!I_ARST_N || rst)
    quiet && $rose(req) |-> ##[1:8] ack) else $error("request left unanswered");
  a_req_drops: assert property (quiet && $rose(ack) |-> ##[1:6] !req)
    else $error("request not dropped after acknowledge");
  a_req_needs_busy: assert property (quiet && req |-> bsy)
    else $error("request while bus free");
  a_phase_steady: assert property (quiet && req && $past(req) |-> $stable({cd, io, msg}))
    else $error("phase lines moved during request");
  a_rst_clears: assert property (rst [*4] |-> !(tgt_bsy_oe || tgt_sel_oe || tgt_req_oe
    || ini_ack_oe) && tgt_db_oe == 8'h00) else $error("drivers held during bus reset");
  // Busy retaken at the end of reselection follows select, not a bus free span
  a_free_wait: assert property ($rose(tgt_bsy_oe) && !$past(tgt_sel_oe)
    |-> free_cnt >= 6'd8) else $error("busy asserted too soon after bus free");
  a_arb_wait: assert property ($rose(tgt_sel_oe) |-> arb_cnt >= 6'd22)
    else $error("select asserted before arbitration delay");
  c_byte_done: cover property (req && ack);
  c_reselect: cover property ($rose(tgt_sel_oe));
  c_bus_reset: cover property (rst [*4]);
endmodule // sbsi_chk

// ### tb.sv
// Bench joining target and initiator ends over the shared bus
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module tb;
  logic       clk, arst_n;                           // Clock, reset
  logic       t_start, t_rel, t_tx_v, t_rx_req;      // Target stimulus
  logic       t_rx_rdy, i_atn, i_brst, i_tx_v;       // More stimulus
  logic       i_rx_rdy, par_en;                      // Consumer, check enable
  logic [7:0] t_tx_d, i_tx_d, t_rx_d, i_rx_d;        // Bytes each way
  logic       t_tx_rdy, t_rx_v, t_perr, t_atn, t_brst;  // Target flags
  logic       t_conn, t_lost, i_tx_rdy, i_rx_v, i_conn; // Other flags
  logic [2:0] i_ph;                                  // Phase seen
  sbsi_pkg::sbsi_phase_t t_ph;                       // Phase presented
  int         n_mismatch, compares;                  // Tallies
  sbsi_bus_if bus ();
  sbsi_target i_sbsi_target (.I_CLK(clk), .I_ARST_N(arst_n), .bus(bus),
    .I_OWN_ID(3'h5), .I_PEER_ID(3'h2), .I_PAR_CHK_EN(par_en), .I_START(t_start),
    .I_RELEASE(t_rel), .I_PHASE(t_ph), .I_TX_VALID(t_tx_v), .O_TX_READY(t_tx_rdy),
    .I_TX_DATA(t_tx_d), .I_RX_REQ(t_rx_req), .O_RX_VALID(t_rx_v), .I_RX_READY(t_rx_rdy),
    .O_RX_DATA(t_rx_d), .O_PAR_ERR(t_perr), .O_ATN(t_atn), .O_BUS_RST(t_brst),
    .O_CONNECTED(t_conn), .O_ARB_LOST(t_lost));
  sbsi_initiator i_sbsi_initiator (.I_CLK(clk), .I_ARST_N(arst_n), .bus(bus),
    .I_OWN_ID(3'h2), .I_ATN(i_atn), .I_BUS_RST(i_brst), .I_TX_VALID(i_tx_v),
    .O_TX_READY(i_tx_rdy), .I_TX_DATA(i_tx_d), .O_RX_VALID(i_rx_v), .I_RX_READY(i_rx_rdy),
    .O_RX_DATA(i_rx_d), .O_PHASE(i_ph), .O_CONNECTED(i_conn));
  sbsi_chk i_sbsi_chk (.I_CLK(clk), .I_ARST_N(arst_n), .db(bus.db), .dbp(bus.dbp),
    .bsy(bus.bsy), .sel(bus.sel), .req(bus.req), .ack(bus.ack), .rst(bus.rst),
    .cd(bus.cd), .io(bus.io), .msg(bus.msg), .tgt_db_oe(bus.tgt_db_oe),
    .tgt_bsy_oe(bus.tgt_bsy_oe), .tgt_sel_oe(bus.tgt_sel_oe),
    .tgt_req_oe(bus.tgt_req_oe), .ini_ack_oe(bus.ini_ack_oe));
  // Free-running clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait on a flag; running out counts as a mismatch
  task automatic wait_on(ref logic f, input int n);
    int k;
    k = 0;
    while (f !== 1'b1 && k < n) begin
      @(negedge clk);
      k++;
    end
    `CHK(k < n, 1'b1)
  endtask
  // One byte across the bus in the direction the phase gives
  task automatic xfer(input sbsi_pkg::sbsi_phase_t ph, input logic [7:0] d);
    t_ph = ph;
    tick(4);
    `CHK(i_ph, ph)
    `CHK({bus.msg, bus.cd, bus.io}, ph)
    if (ph[0]) begin
      t_tx_v = 1'b1;
      t_tx_d = d;
      wait_on(t_tx_rdy, 20);
      tick(1);
      t_tx_v = 1'b0;
      wait_on(i_rx_v, 60);
      `CHK(i_rx_d, d)
      i_rx_rdy = 1'b1;
      tick(1);
      i_rx_rdy = 1'b0;
    end else begin
      i_tx_v = 1'b1;
      i_tx_d = d;
      t_rx_req = 1'b1;
      wait_on(i_tx_rdy, 20);
      tick(1);
      i_tx_v = 1'b0;
      wait_on(t_rx_v, 60);
      `CHK(t_rx_d, d)
      `CHK(t_perr, 1'b0)
      t_rx_rdy = 1'b1;
      t_rx_req = 1'b0;
      tick(1);
      t_rx_rdy = 1'b0;
    end
    // Let request and acknowledge both fall before the phase may move;
    // the target still reads the direction until acknowledge is gone
    tick(12);
  endtask
  // Watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    #2_000_000;
    n_mismatch++;
    print_verdict;
  end
  // Main sequence, all stimulus on the falling edge
  initial begin
    logic [2:0] phs [6] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [7:0] dat [6] = '{8'h00, 8'h80, 8'h7f, 8'hff, 8'h01, 8'hfe};
    {arst_n, t_start, t_rel, t_tx_v, t_rx_req, t_rx_rdy, i_atn, i_brst} = 8'h00;
    {i_tx_v, i_rx_rdy, t_tx_d, i_tx_d, t_ph} = 21'h000000;
    {n_mismatch, compares, par_en} = {32'h0, 32'h0, 1'b1};
    tick(20);
    arst_n = 1'b1;
    for (int r = 0; r < 2; r++) begin
      tick(2);
      t_start = 1'b1;
      tick(1);
      t_start = 1'b0;
      wait_on(i_conn, 100);
      wait_on(t_conn, 8);
      `CHK(t_conn, 1'b1)
      $display("test reselect done");
      if (r == 0) begin
        for (int j = 0; j < 6; j++) xfer(phs[j], dat[j]);
        $display("test phases done");
        i_atn = 1'b1;
        tick(5);
        `CHK(t_atn, 1'b1)
        i_atn = 1'b0;
        tick(5);
        `CHK(t_atn, 1'b0)
        $display("test attention done");
        t_rel = 1'b1;
        tick(1);
        t_rel = 1'b0;
        tick(10);
        `CHK({t_conn, bus.tgt_bsy_oe}, 2'h0)
        $display("test release done");
      end
    end
    i_brst = 1'b1;
    tick(6);
    `CHK({t_brst, t_conn, bus.tgt_bsy_oe}, 3'h4)
    i_brst = 1'b0;
    tick(5);
    `CHK(t_brst, 1'b0)
    $display("test bus reset done");
    print_verdict;
  end
endmodule // tb
